// >>> src/phf_pkg.sv
package phf_pkg;

    // line octets
    localparam logic [7:0]  FLAG_OCTET   = 8'h7E;
    localparam logic [7:0]  ESC_OCTET    = 8'h7D;
    localparam logic [7:0]  ESC_FLIP     = 8'h20;
    localparam logic [7:0]  ALL_STATIONS = 8'hFF;
    localparam logic [7:0]  UI_CONTROL   = 8'h03;
    localparam logic [2:0]  OCTET_LAST   = 3'h7;

    // reflected ccitt fcs
    localparam logic [15:0] FCS_INIT     = 16'hFFFF;
    localparam logic [15:0] FCS_POLY     = 16'h8408;
    localparam logic [15:0] FCS_GOOD     = 16'hF0B8;

    // class bounds
    localparam logic [15:0] PROTO_LINK_LO = 16'hC000;
    localparam logic [15:0] PROTO_NCP_LO  = 16'h8000;
    localparam logic [15:0] PROTO_NET_HI  = 16'h3FFF;

    // length limits
    localparam logic [11:0] MAXLEN_RESET  = 12'h80E;
    localparam logic [11:0] MIN_FRAME_LEN = 12'h002;

    // register byte offsets
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_MAXLEN   = 8'h04;
    localparam logic [7:0]  REG_STATUS   = 8'h08;
    localparam logic [7:0]  REG_CNT_BASE = 8'h10;
    localparam logic [7:0]  REG_CNT_SPAN = 8'h28;

    // register fields
    localparam int          CTRL_RX_EN      = 0;
    localparam int          CTRL_ACF_OMIT   = 1;
    localparam int          CTRL_PF_SHRINK  = 2;
    localparam int          CTRL_TX_ABORT   = 3;
    localparam logic [2:0]  CTRL_RESET      = 3'h1;
    localparam int          STAT_IN_FRAME   = 0;
    localparam int          STAT_CLASS_LSB  = 4;
    localparam int          STAT_PROTO_LSB  = 16;

    // counter indices
    localparam int          CNT_CRC      = 0;
    localparam int          CNT_ALIGN    = 1;
    localparam int          CNT_SHORT    = 2;
    localparam int          CNT_LONG     = 3;
    localparam int          CNT_ABORT    = 4;
    localparam int          CNT_OVERRUN  = 5;
    localparam int          CNT_MISSED   = 6;
    localparam int          CNT_LF       = 7;
    localparam int          CNT_UNDERRUN = 8;
    localparam int          CNT_TXABORT  = 9;
    localparam int          CNT_NUM      = 10;

    typedef enum logic [1:0] {
        CLS_NET   = 2'h0,
        CLS_OTHER = 2'h1,
        CLS_LINK  = 2'h2,
        CLS_NCP   = 2'h3
    } phf_class_t;

    typedef enum logic [0:0] {
        ST_HUNT  = 1'h0,
        ST_FRAME = 1'h1
    } phf_state_t;

    typedef enum logic [2:0] {
        HP_ADDR = 3'h0,
        HP_CTRL = 3'h1,
        HP_PHI  = 3'h3,
        HP_PLO  = 3'h2,
        HP_INFO = 3'h6
    } phf_hdr_t;

    function automatic logic [15:0] fcs_next(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        logic        fb;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            fb = c[0] ^ data[i];
            c  = {1'b0, c[15:1]};
            if (fb) begin
                c = c ^ FCS_POLY;
            end
        end
        return c;
    endfunction

    function automatic phf_class_t classify(input logic [15:0] proto);
        if (proto >= PROTO_LINK_LO) begin
            return CLS_LINK;
        end else if (proto >= PROTO_NCP_LO) begin
            return CLS_NCP;
        end else if (proto <= PROTO_NET_HI) begin
            return CLS_NET;
        end
        return CLS_OTHER;
    endfunction

endpackage

// >>> src/phf_cnt_if.sv
`timescale 1ns/100ps
`default_nettype none
interface phf_cnt_if #(
    parameter int N = 10,
    parameter int W = 16
);
    logic [N-1:0]        evt;
    logic [N-1:0]        clr;
    logic [N-1:0][W-1:0] val;

    modport src  (output evt, output clr, input val);
    modport bank (input evt, input clr, output val);
endinterface
`default_nettype wire

// >>> src/phf_line_sync.sv
`timescale 1ns/100ps
`default_nettype none
module phf_line_sync (
    // system
    input  wire logic clock,
    input  wire logic rst_n,
    // line pins
    input  wire logic line_clk,
    input  wire logic line_data,
    // recovered bits
    output logic      bit_valid,
    output logic      bit_data
);
    logic [2:0] clk_s;
    logic [2:0] dat_s;
    logic       clk_lvl;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_s <= 3'h0;
            dat_s <= 3'h0;
        end else begin
            clk_s <= {clk_s[1:0], line_clk};
            dat_s <= {dat_s[1:0], line_data};
        end
    end

    // moves once stages 2 and 3 agree
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_lvl   <= 1'b0;
            bit_valid <= 1'b0;
            bit_data  <= 1'b0;
        end else begin
            bit_valid <= 1'b0;
            if (clk_s[1] == clk_s[2]) begin
                clk_lvl <= clk_s[2];
                if (clk_s[2] && !clk_lvl) begin
                    bit_valid <= 1'b1;
                    bit_data  <= dat_s[2];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> src/phf_err_counters.sv
`timescale 1ns/100ps
`default_nettype none
module phf_err_counters #(
    parameter int N = 10,
    parameter int W = 16
) (
    // system
    input  wire logic clock,
    input  wire logic rst_n,
    // events in, values out
    phf_cnt_if.bank   bus
);
    generate
        if (N < 1 || W < 1 || W > 32) begin : g_bad
            $error("bad N or W");
        end
    endgenerate

    // clear with event loads one; saturates
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus.val <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (bus.evt[i] && bus.clr[i]) begin
                    bus.val[i] <= W'(1);
                end else if (bus.evt[i] && bus.val[i] != {W{1'b1}}) begin
                    bus.val[i] <= bus.val[i] + W'(1);
                end else if (bus.clr[i]) begin
                    bus.val[i] <= '0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> src/phf_frame_rx.sv
// Notes on behaviour
// - flag octet 7E opens and closes each frame
// - one flag may close one frame and open the next
// - flag hunt never stops
// - address octet must be FF
// - control octet must be 03
// - two-octet protocol field
// - protocol classes: C000-FFFF link, 8000-BFFF ncp, 0-3FFF network
// - empty information field is legal
// - 16-bit check sequence before closing flag
// - link control frames keep address and control
// - address/control omission and protocol shrink selectable
// - bad fcs: discard, count crc
// - non-octet length: discard, count alignment
// - under two octets: discard, count short
// - over maximum: discard, count long
// - aborts counted
// - buffer too slow: count overrun
// - no buffer: drop, count missed
// - marks not both set: drop, count, free buffer
// - count transmit underrun
// - software transmit abort, counted
// - default maximum 2062 octets
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module phf_frame_rx
    import phf_pkg::*;
#(
    parameter int LEN_W = 12,
    parameter int CNT_W = 16
) (
    // system
    input  wire logic              clock,
    input  wire logic              rst_n,
    // apb slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // serial line
    input  wire logic              line_clk,
    input  wire logic              line_data,
    // buffer memory side
    input  wire logic              buf_avail,
    input  wire logic              out_ready,
    output logic                   out_valid,
    output logic [7:0]             out_data,
    output logic                   desc_valid,
    output logic                   desc_keep,
    output logic                   desc_first,
    output logic                   desc_last,
    output logic [1:0]             desc_class,
    output logic [15:0]            desc_proto,
    output logic [LEN_W-1:0]       desc_len,
    output logic                   buf_release,
    // transmit side
    input  wire logic              tx_busy,
    input  wire logic              tx_underrun,
    output logic                   tx_abort
);
    generate
        if (LEN_W < 12 || LEN_W > 16 || CNT_W < 1 || CNT_W > 31) begin : g_bad
            $error("bad LEN_W or CNT_W");
        end
    endgenerate

    logic                 bit_valid;
    logic                 bit_data;
    logic                 rx_en;
    logic                 acf_omit;
    logic                 pf_shrink;
    logic [LEN_W-1:0]     max_len;
    phf_state_t           state;
    phf_hdr_t             hdr;
    logic [7:0]           win;
    logic [2:0]           bitcnt;
    logic                 esc_pend;
    logic [LEN_W-1:0]     len;
    logic [15:0]          fcs;
    logic [15:0]          proto;
    logic                 full_hdr;
    logic                 hdr_bad;
    logic                 missed;
    logic                 lost_first;
    logic                 lost_later;
    logic                 ack;
    logic [31:0]          rd_q;
    logic                 err_q;
    logic [31:0]          rd_mux;
    logic                 rd_hit;

    phf_cnt_if #(.N(CNT_NUM), .W(CNT_W)) cnt ();

    phf_line_sync u_sync (
        .clock     (clock),
        .rst_n     (rst_n),
        .line_clk  (line_clk),
        .line_data (line_data),
        .bit_valid (bit_valid),
        .bit_data  (bit_data)
    );

    phf_err_counters #(.N(CNT_NUM), .W(CNT_W)) u_cnt (
        .clock (clock),
        .rst_n (rst_n),
        .bus   (cnt.bank)
    );

    // lsb first
    wire       bit_ev    = bit_valid & rx_en;
    wire [7:0] next_win  = {bit_data, win[7:1]};
    wire       in_frame  = (state == ST_FRAME);
    wire       flag_hit  = bit_ev && (next_win == FLAG_OCTET);
    // abort is escape then flag; all-ones data must not abort
    wire       abort_hit = flag_hit && in_frame && esc_pend;
    wire       byte_end  = bit_ev && in_frame && (bitcnt == OCTET_LAST) && !flag_hit;
    wire       esc_seen  = byte_end && (next_win == ESC_OCTET);
    wire       octet_ev  = byte_end && !esc_seen;
    wire [7:0] octet     = esc_pend ? (next_win ^ ESC_FLIP) : next_win;
    wire       first_oct = octet_ev && (len == '0);
    wire       miss_now  = first_oct ? !buf_avail : missed;

    // empty flag pairs are ignored
    wire close_ok  = flag_hit && in_frame && (bitcnt == OCTET_LAST) && (len != '0) && !esc_pend;
    wire close_mis = flag_hit && in_frame && (bitcnt != OCTET_LAST) && !esc_pend;

    // verdict at close
    phf_class_t cls;
    assign cls = classify(proto);
    wire f_short = (len < LEN_W'(MIN_FRAME_LEN));
    wire f_long  = (len > max_len);
    wire f_fcs   = (fcs != FCS_GOOD);
    wire f_lf    = !missed && (lost_first || lost_later);
    wire f_hdr   = hdr_bad || (hdr != HP_INFO) || ((cls == CLS_LINK) && !full_hdr);
    wire keep    = !(missed || f_short || f_long || f_fcs || f_lf || f_hdr);

    // frame state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state  <= ST_HUNT;
            win    <= 8'h00;
            bitcnt <= 3'h0;
        end else if (!rx_en) begin
            state <= ST_HUNT;
        end else if (bit_ev) begin
            win <= next_win;
            unique case (state)
                ST_HUNT: begin
                    if (flag_hit) begin
                        state  <= ST_FRAME;
                        bitcnt <= 3'h0;
                    end
                end
                ST_FRAME: begin
                    if (flag_hit) begin
                        bitcnt <= 3'h0;
                    end else begin
                        bitcnt <= bitcnt + 3'h1;
                    end
                end
            endcase
        end
    end

    // octet count and fcs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            esc_pend <= 1'b0;
            len      <= '0;
            fcs      <= FCS_INIT;
        end else if (flag_hit) begin
            esc_pend <= 1'b0;
            len      <= '0;
            fcs      <= FCS_INIT;
        end else if (byte_end) begin
            esc_pend <= esc_seen;
            if (octet_ev) begin
                if (len != {LEN_W{1'b1}}) begin
                    len <= len + LEN_W'(1);
                end
                fcs <= fcs_next(fcs, octet);
            end
        end
    end

    // header parse
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hdr      <= HP_ADDR;
            proto    <= 16'h0000;
            full_hdr <= 1'b0;
            hdr_bad  <= 1'b0;
        end else if (flag_hit) begin
            hdr      <= HP_ADDR;
            proto    <= 16'h0000;
            full_hdr <= 1'b0;
            hdr_bad  <= 1'b0;
        end else if (octet_ev) begin
            if (hdr == HP_ADDR && octet == ALL_STATIONS) begin
                full_hdr <= 1'b1;
                hdr      <= HP_CTRL;
            end else if (hdr == HP_ADDR && !acf_omit) begin
                hdr_bad <= 1'b1;
                hdr     <= HP_INFO;
            end else if (hdr == HP_CTRL) begin
                hdr_bad <= (octet != UI_CONTROL);
                hdr     <= HP_PHI;
            end else if (hdr == HP_ADDR || hdr == HP_PHI) begin
                if (pf_shrink && octet[0]) begin
                    proto <= {8'h00, octet};
                    hdr   <= HP_INFO;
                end else begin
                    proto[15:8] <= octet;
                    hdr         <= HP_PLO;
                end
            end else if (hdr == HP_PLO) begin
                proto[7:0] <= octet;
                hdr        <= HP_INFO;
            end
        end
    end

    // octets to buffer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_valid  <= 1'b0;
            out_data   <= 8'h00;
            missed     <= 1'b0;
            lost_first <= 1'b0;
            lost_later <= 1'b0;
        end else begin
            if (out_valid && out_ready) begin
                out_valid <= 1'b0;
            end
            if (flag_hit) begin
                missed     <= 1'b0;
                lost_first <= 1'b0;
                lost_later <= 1'b0;
            end else if (octet_ev) begin
                missed <= miss_now;
                if (!miss_now) begin
                    if (out_valid && !out_ready) begin
                        lost_first <= lost_first | first_oct;
                        lost_later <= lost_later | !first_oct;
                    end else begin
                        out_valid <= 1'b1;
                        out_data  <= octet;
                    end
                end
            end
        end
    end

    // descriptor at close
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            desc_valid  <= 1'b0;
            desc_keep   <= 1'b0;
            desc_first  <= 1'b0;
            desc_last   <= 1'b0;
            desc_class  <= CLS_NET;
            desc_proto  <= 16'h0000;
            desc_len    <= '0;
            buf_release <= 1'b0;
        end else begin
            desc_valid  <= close_ok;
            buf_release <= close_ok && !keep;
            if (close_ok) begin
                desc_keep  <= keep;
                desc_first <= !missed && !lost_first;
                desc_last  <= !missed && !lost_later;
                desc_class <= cls;
                desc_proto <= proto;
                desc_len   <= len;
            end
        end
    end

    // counter events
    always_comb begin
        cnt.evt               = '0;
        cnt.evt[CNT_SHORT]    = close_ok && !missed && f_short;
        cnt.evt[CNT_LONG]     = close_ok && !missed && !f_short && f_long;
        cnt.evt[CNT_CRC]      = close_ok && !missed && !f_short && !f_long && f_fcs;
        cnt.evt[CNT_LF]       = close_ok && !f_short && !f_long && !f_fcs && f_lf;
        cnt.evt[CNT_ALIGN]    = close_mis;
        cnt.evt[CNT_ABORT]    = abort_hit && (len != '0);
        cnt.evt[CNT_OVERRUN]  = octet_ev && !miss_now && out_valid && !out_ready;
        cnt.evt[CNT_MISSED]   = first_oct && !buf_avail;
        cnt.evt[CNT_UNDERRUN] = tx_underrun;
        cnt.evt[CNT_TXABORT]  = tx_abort && tx_busy;
    end

    // apb: one wait state
    wire       apb_access = psel && penable;
    wire [7:0] cnt_off    = paddr - REG_CNT_BASE;
    wire [3:0] cnt_idx    = cnt_off[5:2];
    wire       cnt_hit    = (paddr >= REG_CNT_BASE) && (cnt_off < REG_CNT_SPAN) && (paddr[1:0] == 2'h0);
    wire       wr_commit  = apb_access && ack && pwrite && !err_q;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == REG_CTRL) begin
            rd_mux[CTRL_RX_EN]     = rx_en;
            rd_mux[CTRL_ACF_OMIT]  = acf_omit;
            rd_mux[CTRL_PF_SHRINK] = pf_shrink;
        end else if (paddr == REG_MAXLEN) begin
            rd_mux[LEN_W-1:0] = max_len;
        end else if (paddr == REG_STATUS) begin
            rd_mux[STAT_IN_FRAME]                  = in_frame;
            rd_mux[STAT_CLASS_LSB+1:STAT_CLASS_LSB] = desc_class;
            rd_mux[STAT_PROTO_LSB+15:STAT_PROTO_LSB] = desc_proto;
        end else if (cnt_hit) begin
            rd_mux[CNT_W-1:0] = cnt.val[cnt_idx];
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_comb begin
        cnt.clr = '0;
        for (int i = 0; i < CNT_NUM; i++) begin
            cnt.clr[i] = wr_commit && cnt_hit && (cnt_idx == 4'(i));
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack   <= 1'b0;
            rd_q  <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            ack <= apb_access && !ack;
            if (apb_access && !ack) begin
                rd_q  <= pwrite ? 32'h0000_0000 : rd_mux;
                err_q <= !rd_hit;
            end
        end
    end

    assign pready  = ack;
    assign prdata  = rd_q;
    assign pslverr = ack && err_q;

    // software registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {pf_shrink, acf_omit, rx_en} <= CTRL_RESET;
            max_len                       <= LEN_W'(MAXLEN_RESET);
            tx_abort                      <= 1'b0;
        end else begin
            tx_abort <= 1'b0;
            if (wr_commit && paddr == REG_CTRL) begin
                rx_en     <= pwdata[CTRL_RX_EN];
                acf_omit  <= pwdata[CTRL_ACF_OMIT];
                pf_shrink <= pwdata[CTRL_PF_SHRINK];
                tx_abort  <= pwdata[CTRL_TX_ABORT];
            end
            if (wr_commit && paddr == REG_MAXLEN) begin
                max_len <= pwdata[LEN_W-1:0];
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/phf_rx_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module phf_rx_monitor
    import phf_pkg::*;
(
    // system
    input wire logic        clock,
    input wire logic        rst_n,
    // apb
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // buffer side
    input wire logic        out_ready,
    input wire logic        out_valid,
    input wire logic [7:0]  out_data,
    input wire logic        desc_valid,
    input wire logic        desc_keep,
    input wire logic        desc_first,
    input wire logic        desc_last,
    input wire logic [1:0]  desc_class,
    input wire logic [15:0] desc_proto,
    input wire logic        buf_release,
    input wire logic        tx_abort
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_ack_pulse; pready |=> !pready; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_lat; psel && !penable |=> !pready ##1 pready; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack latency");
    property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("bad error");
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
    a_hold: assert property (p_hold) else $error("octet dropped");
    property p_desc_pulse; desc_valid |=> !desc_valid; endproperty
    a_desc_pulse: assert property (p_desc_pulse) else $error("desc not pulse");
    property p_keep_marks; desc_valid && desc_keep |-> desc_first && desc_last; endproperty
    a_keep_marks: assert property (p_keep_marks) else $error("marks missing");
    property p_release;
        desc_valid || buf_release |-> desc_valid && (buf_release == !desc_keep);
    endproperty
    a_release: assert property (p_release) else $error("bad release");
    property p_class;
        desc_valid && desc_keep |-> desc_class == (desc_proto >= PROTO_LINK_LO ? 2'h2 :
            desc_proto >= PROTO_NCP_LO ? 2'h3 : desc_proto <= PROTO_NET_HI ? 2'h0 : 2'h1);
    endproperty
    a_class: assert property (p_class) else $error("bad class");
    property p_abort;
        psel && penable && pready && pwrite && paddr == REG_CTRL && pwdata[3] |=> tx_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    c_keep: cover property (desc_valid && desc_keep);
    c_drop: cover property (buf_release);
    c_err: cover property (pslverr);
endmodule
bind phf_frame_rx phf_rx_monitor u_mon (.*);
`default_nettype wire

// >>> tb/phf_line_peer.sv
`timescale 1ns/100ps
`default_nettype none
module phf_line_peer
    import phf_pkg::*;
(
    // line pins
    output logic line_clk,
    output logic line_data
);
    initial begin
        line_clk  = 1'b0;
        line_data = 1'b1;
    end
    function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ d[i]) ? ({1'b0, c[15:1]} ^ FCS_POLY) : {1'b0, c[15:1]};
        end
        return c;
    endfunction
    // data on the fall; idle clock low
    task automatic raw(input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            line_clk  = 1'b0;
            line_data = v[i];
            #200 line_clk = 1'b1;
            #200;
        end
        line_clk  = 1'b0;
        line_data = ~line_data;
    endtask
    task automatic esc(input logic [7:0] v);
        if (v == FLAG_OCTET || v == ESC_OCTET) begin
            raw(ESC_OCTET, 8);
            raw(v ^ ESC_FLIP, 8);
        end else begin
            raw(v, 8);
        end
    endtask
    task automatic frame(input logic [7:0] d[$], input bit bad, input bit opn);
        logic [15:0] c;
        c = FCS_INIT;
        if (opn) begin
            raw(FLAG_OCTET, 8);
        end
        foreach (d[i]) begin
            c = crc16(c, d[i]);
            esc(d[i]);
        end
        c = ~c ^ {15'h0, bad};
        esc(c[7:0]);
        esc(c[15:8]);
        raw(FLAG_OCTET, 8);
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_ppp_hdlc_frame_receiver.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ppp_hdlc_frame_receiver
    import phf_pkg::*;
;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, line_clk, line_data;
    logic        buf_avail, out_ready, out_valid, desc_valid, desc_keep, desc_first, desc_last;
    logic        buf_release, tx_busy, tx_underrun, tx_abort, err;
    logic [7:0]  paddr, out_data, q[$], got[$];
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  desc_class;
    logic [15:0] desc_proto;
    logic [11:0] desc_len;
    logic [15:0] pv[4] = '{16'h0021, 16'h4001, 16'h8021, 16'hC021};
    logic [1:0]  cl[4] = '{CLS_NET, CLS_OTHER, CLS_NCP, CLS_LINK};
    int          error_cnt, checks, cyc, dn, exp_c[CNT_NUM];
    phf_frame_rx #(.LEN_W(12), .CNT_W(16)) dut (.clock, .rst_n, .paddr, .psel, .penable,
        .pwrite, .pwdata, .pready, .prdata, .pslverr, .line_clk, .line_data, .buf_avail,
        .out_ready, .out_valid, .out_data, .desc_valid, .desc_keep, .desc_first, .desc_last,
        .desc_class, .desc_proto, .desc_len, .buf_release, .tx_busy, .tx_underrun, .tx_abort);
    phf_line_peer peer (.line_clk, .line_data);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            final_report();
        end
        if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
        if (desc_valid === 1'b1) dn++;
    end
    task automatic final_report();
        if (error_cnt == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input bit ok);
        checks++;
        if (!ok) begin
            error_cnt++;
            $display("ERROR %0t check %0d failed", $time, checks);
        end
    endtask
    task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
        int t = 0;
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (t >= 20) chk(0);
    endtask
    task automatic cnts();
        for (int i = 0; i < CNT_NUM; i++) begin
            apb(0, REG_CNT_BASE + 8'(4 * i), 32'h0);
            chk(rd === 32'(exp_c[i]));
        end
    endtask
    task automatic mk(input logic [15:0] p, input int n);
        q = '{ALL_STATIONS, UI_CONTROL, p[15:8], p[7:0]};
        for (int i = 0; i < n; i++) q.push_back(i == 0 ? FLAG_OCTET : 8'($urandom));
    endtask
    task automatic run(input bit bad, input bit opn);
        got.delete();
        peer.frame(q, bad, opn);
        repeat (30) @(posedge clock);
    endtask
    function automatic bit same();
        same = got.size() == q.size() + 2;
        if (same) foreach (q[i]) same &= got[i] === q[i];
    endfunction
    initial begin
        {psel, penable, pwrite, tx_busy, tx_underrun, paddr, pwdata} = '0;
        {buf_avail, out_ready, rst_n} = 3'b110;
        void'($urandom(98));
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        apb(0, REG_MAXLEN, 32'h0);
        chk(rd === 32'd2062);
        apb(0, REG_CTRL, 32'h0);
        chk(rd === 32'h1);
        for (int k = 0; k < 4; k++) begin
            mk(pv[k], 2 * k);
            run(0, k == 0);
            chk(dn === k + 1 && desc_keep === 1'b1 && desc_class === cl[k]);
            chk(desc_proto === pv[k] && desc_len === 12'(q.size() + 2) && same());
        end
        mk(16'h0021, 2);
        run(1, 1);
        exp_c[CNT_CRC]++;
        chk(desc_keep === 1'b0);
        peer.raw(FLAG_OCTET, 8);
        peer.raw(8'h55, 8);
        peer.raw(FLAG_OCTET, 8);
        exp_c[CNT_SHORT]++;
        peer.raw(8'h55, 8);
        peer.raw(8'h00, 3);
        peer.raw(FLAG_OCTET, 8);
        exp_c[CNT_ALIGN]++;
        peer.raw(8'h55, 8);
        peer.raw(ESC_OCTET, 8);
        peer.raw(FLAG_OCTET, 8);
        exp_c[CNT_ABORT]++;
        repeat (30) @(posedge clock);
        buf_avail <= 1'b0;
        mk(16'h0021, 1);
        run(0, 1);
        buf_avail <= 1'b1;
        exp_c[CNT_MISSED]++;
        chk(desc_keep === 1'b0 && got.size() == 0);
        out_ready <= 1'b0;
        mk(16'h0021, 0);
        run(0, 1);
        out_ready <= 1'b1;
        exp_c[CNT_OVERRUN] += 5;
        exp_c[CNT_LF]++;
        apb(1, REG_MAXLEN, 32'h5);
        run(0, 1);
        exp_c[CNT_LONG]++;
        apb(1, REG_MAXLEN, 32'd2062);
        tx_busy <= 1'b1;
        apb(1, REG_CTRL, 32'h9);
        exp_c[CNT_TXABORT]++;
        @(posedge clock);
        tx_busy <= 1'b0;
        tx_underrun <= 1'b1;
        repeat (3) @(posedge clock);
        tx_underrun <= 1'b0;
        exp_c[CNT_UNDERRUN] += 3;
        cnts();
        apb(1, REG_CNT_BASE, 32'h0);
        exp_c[CNT_CRC] = 0;
        apb(0, 8'h0C, 32'h0);
        chk(err === 1'b1 && rd === 32'h0);
        apb(1, REG_CTRL, 32'h7);
        q = '{8'h21, 8'h33};
        run(0, 1);
        chk(desc_keep === 1'b1 && desc_proto === 16'h0021 && desc_class === 2'h0);
        q = '{8'hC0, 8'h21};
        run(0, 0);
        chk(desc_keep === 1'b0);
        cnts();
        final_report();
    end
endmodule
`default_nettype wire
